// *** hw/host_bus_dma_request_port.v ***
/*
 * Data bits 0 to 15, strobes, chip select and DMA request pins of the
 * microprocessor-facing parallel port, with the host and peripheral
 * hardware configuration registers and a small buffer memory.
 * Assumes asynchronous strobes and select from the pins, and DMA needs
 * from internal controller logic on CLK_IN.
 */
`timescale 1ns/1ns
`include "host_port_regs.vh"
module host_bus_dma_request_port #(
    parameter BUF_DEPTH = `BUF_DEPTH,
    parameter BUF_ADDR_W = `BUF_ADDR_W
)
(
    input wire CLK_IN,
    input wire NRST_IN,
    input wire CS_N_IN,
    input wire RD_N_IN,
    input wire WR_N_IN,
    input wire [7:0] ADDR_IN,
    input wire [BUF_ADDR_W-1:0] BUF_ADDR_IN,
    input wire [15:0] DATA_IN,
    output reg [15:0] DATA_OUT,
    output reg [15:0] DATA_OE_OUT,
    input wire HOST_XFER_NEED_IN,
    input wire PERIPH_XFER_NEED_IN,
    input wire HOST_DMA_ACKNOWLEDGE_IN,
    output reg HOST_DMA_REQUEST_OUT,
    output reg PERIPH_DMA_REQUEST_OUT,
    output reg HOST_GRANT_OUT,
    output reg PERIPH_GRANT_OUT
);
    reg [2:0] cs_sync_reg;
    reg [2:0] rd_sync_reg;
    reg [2:0] wr_sync_reg;
    reg [2:0] ack_sync_reg;
    reg cs_reg;
    reg rd_reg;
    reg wr_reg;
    reg ack_reg;
    reg [15:0] host_hardware_configuration_reg;
    reg [15:0] periph_hardware_configuration_reg;
    wire [15:0] buf_rd_data;
    wire wr_rise;
    wire sel_read;
    wire buf_wr;
    wire shared_dma_channel;
    wire host_req_active;
    wire periph_req_active;
    wire ack_active;
    reg [15:0] rd_mux;

    // Requests leave reset at the inactive level of the reset polarity,
    // so no DMA controller sees a transfer asked for during reset
    localparam [15:0] HCFG_RESET = `HOST_HW_CFG_RESET;
    localparam [15:0] PCFG_RESET = `PERIPH_HW_CFG_RESET;
    localparam [0:0] HREQ_IDLE = ~HCFG_RESET[`HCFG_DREQ_POL_BIT];
    localparam [0:0] PREQ_IDLE = ~PCFG_RESET[`PCFG_DREQ_POL_BIT];

    // Three stages; a level counts once stages two and three agree
    always @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            cs_sync_reg <= 3'h7;
            rd_sync_reg <= 3'h7;
            wr_sync_reg <= 3'h7;
            // Acknowledge idles high through its pull-up; starting the
            // filter there keeps a false grant out of the first cycles
            ack_sync_reg <= 3'h7;
            cs_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            ack_reg <= 1'b1;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[1:0], CS_N_IN};
            rd_sync_reg <= {rd_sync_reg[1:0], RD_N_IN};
            wr_sync_reg <= {wr_sync_reg[1:0], WR_N_IN};
            ack_sync_reg <= {ack_sync_reg[1:0], HOST_DMA_ACKNOWLEDGE_IN};
            if (cs_sync_reg[1] == cs_sync_reg[2])
            begin
                cs_reg <= ~cs_sync_reg[2];
            end
            if (rd_sync_reg[1] == rd_sync_reg[2])
            begin
                rd_reg <= ~rd_sync_reg[2];
            end
            if (wr_sync_reg[1] == wr_sync_reg[2])
            begin
                wr_reg <= ~wr_sync_reg[2];
            end
            if (ack_sync_reg[1] == ack_sync_reg[2])
            begin
                ack_reg <= ack_sync_reg[2];
            end
        end
    end

    // Write commits at the strobe release, when the data has settled.
    // A write started while selected but finished after deselect is lost.
    reg wr_seen_reg;
    always @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            wr_seen_reg <= 1'b0;
        end
        else
        begin
            wr_seen_reg <= wr_reg & cs_reg;
        end
    end

    assign wr_rise = wr_seen_reg & ~(wr_reg & cs_reg) & cs_reg;
    assign sel_read = rd_reg & cs_reg & ~wr_reg;
    assign buf_wr = wr_rise && (ADDR_IN == `BUF_ACCESS_OFFSET);

    always @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            host_hardware_configuration_reg <= `HOST_HW_CFG_RESET;
            periph_hardware_configuration_reg <= `PERIPH_HW_CFG_RESET;
        end
        else if (wr_rise)
        begin
            if (ADDR_IN == `HOST_HW_CFG_WRITE_OFFSET)
            begin
                host_hardware_configuration_reg <= DATA_IN;
            end
            if (ADDR_IN == `PERIPH_HW_CFG_WRITE_OFFSET)
            begin
                periph_hardware_configuration_reg <= DATA_IN;
            end
        end
    end

    port_buffer_mem #(
        .DATA_W(16),
        .ADDR_W(BUF_ADDR_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_in(CLK_IN),
        .wr_en_in(buf_wr),
        .addr_in(BUF_ADDR_IN),
        .wr_data_in(DATA_IN),
        .rd_data_out(buf_rd_data)
    );

    always @*
    begin
        case (ADDR_IN)
            `HOST_HW_CFG_READ_OFFSET: rd_mux = host_hardware_configuration_reg;
            `PERIPH_HW_CFG_READ_OFFSET:
                rd_mux = periph_hardware_configuration_reg;
            `BUF_ACCESS_OFFSET: rd_mux = buf_rd_data;
            default: rd_mux = 16'h0000;
        endcase
    end

    always @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            DATA_OUT <= 16'h0000;
            DATA_OE_OUT <= 16'h0000;
        end
        else
        begin
            DATA_OUT <= sel_read ? rd_mux : 16'h0000;
            DATA_OE_OUT <= sel_read ? 16'hffff : 16'h0000;
        end
    end

    assign shared_dma_channel =
        host_hardware_configuration_reg[`HCFG_SHARED_DMA_BIT];
    assign ack_active =
        ack_reg == host_hardware_configuration_reg[`HCFG_DACK_POL_BIT];
    assign host_req_active = HOST_XFER_NEED_IN |
        (shared_dma_channel & PERIPH_XFER_NEED_IN);
    assign periph_req_active = ~shared_dma_channel & PERIPH_XFER_NEED_IN;

    always @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            HOST_DMA_REQUEST_OUT <= HREQ_IDLE;
            PERIPH_DMA_REQUEST_OUT <= PREQ_IDLE;
        end
        else
        begin
            HOST_DMA_REQUEST_OUT <= ~(host_req_active ^
                host_hardware_configuration_reg[`HCFG_DREQ_POL_BIT]);
            PERIPH_DMA_REQUEST_OUT <= ~(periph_req_active ^
                periph_hardware_configuration_reg[`PCFG_DREQ_POL_BIT]);
        end
    end

    always @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            HOST_GRANT_OUT <= 1'b0;
            PERIPH_GRANT_OUT <= 1'b0;
        end
        else
        begin
            HOST_GRANT_OUT <= ack_active & HOST_XFER_NEED_IN;
            PERIPH_GRANT_OUT <= ack_active & shared_dma_channel &
                PERIPH_XFER_NEED_IN & ~HOST_XFER_NEED_IN;
        end
    end
endmodule // host_bus_dma_request_port

// *** hw/host_port_regs.vh ***
/*
 * Constants for the host-side parallel port: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files under hw/.
 */
// Notes on behaviour
// - Data bits 0 to 15 carry register and buffer transfers and float when idle.
// - Chip select is active low and accesses are taken only while it is low.
// - The host DMA request goes active on a host transfer need, at a level set in the host configuration register.
// - With the shared channel bit set, both DMA channels use the host request and acknowledge pair.
// - A separate peripheral DMA request goes active at a level set in the peripheral configuration register.
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

`define HOST_HW_CFG_OFFSET 8'h20
`define HOST_HW_CFG_READ_OFFSET 8'h20
`define HOST_HW_CFG_WRITE_OFFSET 8'ha0
`define PERIPH_HW_CFG_READ_OFFSET 8'hba
`define PERIPH_HW_CFG_WRITE_OFFSET 8'hbb
`define HOST_HW_CFG_RESET 16'h0000
`define PERIPH_HW_CFG_RESET 16'h0000
`define BUF_ACCESS_OFFSET 8'h40

`define HCFG_DREQ_POL_BIT 5
`define HCFG_DACK_POL_BIT 6
`define HCFG_SHARED_DMA_BIT 7
`define PCFG_DREQ_POL_BIT 6
`define PCFG_DACK_POL_BIT 7

`define SYNC_STAGES 3
`define BUF_DEPTH 64
`define BUF_ADDR_W 6

`endif

// *** hw/port_buffer_mem.v ***
/*
 * Small buffer memory for the host port, word wide, with registered
 * read data.
 * Assumes one write or one read per cycle from the port logic.
 */
`timescale 1ns/1ns
module port_buffer_mem #(
    parameter DATA_W = 16,
    parameter ADDR_W = 6,
    parameter DEPTH = 64
)
(
    input wire clk_in,
    input wire wr_en_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [DATA_W-1:0] wr_data_in,
    output reg [DATA_W-1:0] rd_data_out
);
    reg [DATA_W-1:0] mem_reg [0:DEPTH-1];

    // No reset: contents are undefined until the host writes them
    always @(posedge clk_in)
    begin
        if (wr_en_in)
        begin
            mem_reg[addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_reg[addr_in];
    end
endmodule // port_buffer_mem

// *** tb/host_port_chk.sv ***
/* Checker for the host port pins and DMA outputs.
   Assumes it is bound onto the host port top module. */
`timescale 1ns/1ns
module host_port_chk (
    input wire CLK_IN,
    input wire NRST_IN,
    input wire CS_N_IN,
    input wire RD_N_IN,
    input wire WR_N_IN,
    input wire HOST_XFER_NEED_IN,
    input wire PERIPH_XFER_NEED_IN,
    input wire [15:0] DATA_OUT,
    input wire [15:0] DATA_OE_OUT,
    input wire HOST_DMA_REQUEST_OUT,
    input wire HOST_GRANT_OUT,
    input wire PERIPH_GRANT_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    // Seven samples cover the three-stage pin filter plus the output flop
    idle_float_a: assert property (
        CS_N_IN [*7] |-> DATA_OE_OUT == 16'h0000)
        else $error("data driven while deselected");
    read_drive_a: assert property (
        (!CS_N_IN && !RD_N_IN && WR_N_IN) [*7] |-> DATA_OE_OUT == 16'hffff)
        else $error("selected read not driven");
    no_read_quiet_a: assert property (
        RD_N_IN [*7] |-> DATA_OE_OUT == 16'h0000)
        else $error("data driven without read");
    out_zero_a: assert property (
        DATA_OE_OUT == 16'h0000 |-> DATA_OUT == 16'h0000)
        else $error("read data left on idle bus");
    host_req_a: assert property (
        $changed(HOST_XFER_NEED_IN) && !PERIPH_XFER_NEED_IN &&
        !$past(PERIPH_XFER_NEED_IN) |=> $changed(HOST_DMA_REQUEST_OUT))
        else $error("host request missed need change");
    host_grant_a: assert property (
        HOST_GRANT_OUT |-> $past(HOST_XFER_NEED_IN))
        else $error("host grant without need");
    periph_grant_a: assert property (
        PERIPH_GRANT_OUT |-> $past(PERIPH_XFER_NEED_IN) &&
        !$past(HOST_XFER_NEED_IN))
        else $error("periph grant without need");
    one_grant_a: assert property (
        !(HOST_GRANT_OUT && PERIPH_GRANT_OUT))
        else $error("both grants at once");
    cover property (!CS_N_IN && !WR_N_IN);
    cover property (DATA_OE_OUT == 16'hffff);
    cover property (PERIPH_GRANT_OUT);
endmodule // host_port_chk

bind host_bus_dma_request_port host_port_chk host_port_chk_inst (.CLK_IN,
    .NRST_IN, .CS_N_IN, .RD_N_IN, .WR_N_IN, .HOST_XFER_NEED_IN,
    .PERIPH_XFER_NEED_IN, .DATA_OUT, .DATA_OE_OUT, .HOST_DMA_REQUEST_OUT,
    .HOST_GRANT_OUT, .PERIPH_GRANT_OUT);

// *** tb/host_cpu_model.sv ***
/* Model of the microprocessor and DMA controller facing the host port.
   Assumes the bench resolves the data wire and calls its tasks. */
`timescale 1ns/1ns
module host_cpu_model (
    input wire clk_in,
    input wire [15:0] bus_in,
    output reg cs_n_out = 1'b1,
    output reg rd_n_out = 1'b1,
    output reg wr_n_out = 1'b1,
    output reg [7:0] addr_out = 8'h00,
    output reg [15:0] data_out = 16'h0000,
    output reg ack_out = 1'b1
);
    task access(input sel, input rd, input [7:0] a, input [15:0] d,
        output [15:0] q);
        @(posedge clk_in);
        cs_n_out <= !sel;
        rd_n_out <= !rd;
        wr_n_out <= rd;
        addr_out <= a;
        data_out <= rd ? ~data_out : d;
        repeat (8) @(posedge clk_in);
        q = bus_in;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        repeat (7) @(posedge clk_in);
        cs_n_out <= 1'b1;
        // Released wire must not keep the last value
        data_out <= ~data_out;
        repeat (7) @(posedge clk_in);
    endtask
    task grant(input v);
        @(posedge clk_in);
        ack_out <= v;
    endtask
endmodule // host_cpu_model

// *** tb/host_bus_dma_request_port_tb_top.sv ***
/* Bench for the host port: register and buffer rows, then deselect,
   DMA polarity and shared-channel cases.
   Assumes the partner model drives strobes and acknowledge. */
`timescale 1ns/1ns
module host_bus_dma_request_port_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg hneed = 1'b0;
    reg pneed = 1'b0;
    reg [5:0] baddr = 6'h05;
    wire cs_n, rd_n, wr_n, ack, hreq, preq, hgnt, pgnt;
    wire [7:0] addr;
    wire [15:0] mdata, dout, oe;
    // Device wins on the bits it enables, the model elsewhere
    wire [15:0] bus = (oe & dout) | (~oe & mdata);
    integer failures = 0, comparisons = 0, i;
    reg [15:0] q;
    reg [24:0] rows [0:8] = '{{1'b1, 8'h20, 16'h0000},
        {1'b0, 8'ha0, 16'h0020}, {1'b1, 8'h20, 16'h0020},
        {1'b0, 8'hbb, 16'h0040}, {1'b1, 8'hba, 16'h0040},
        {1'b0, 8'h40, 16'h5a3c}, {1'b1, 8'h40, 16'h5a3c},
        {1'b0, 8'h77, 16'hffff}, {1'b1, 8'h77, 16'h0000}};
    always #5 clk = ~clk;
    host_cpu_model host_cpu_model_inst (.clk_in(clk), .bus_in(bus),
        .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .addr_out(addr), .data_out(mdata), .ack_out(ack));
    host_bus_dma_request_port host_bus_dma_request_port_inst (.CLK_IN(clk),
        .NRST_IN(rst_n), .CS_N_IN(cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
        .ADDR_IN(addr), .BUF_ADDR_IN(baddr), .DATA_IN(bus), .DATA_OUT(dout),
        .DATA_OE_OUT(oe), .HOST_XFER_NEED_IN(hneed),
        .PERIPH_XFER_NEED_IN(pneed), .HOST_DMA_ACKNOWLEDGE_IN(ack),
        .HOST_DMA_REQUEST_OUT(hreq), .PERIPH_DMA_REQUEST_OUT(preq),
        .HOST_GRANT_OUT(hgnt), .PERIPH_GRANT_OUT(pgnt));
    task check(input string name, input [15:0] exp, input [15:0] seen);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures = failures + 1;
        report_and_stop;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        check("hreq first rst", 16'h0001, {15'h0, hreq});
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("oe idle", 16'h0000, oe);
        check("hreq idle", 16'h0001, {15'h0, hreq});
        check("preq idle", 16'h0001, {15'h0, preq});
        for (i = 0; i < 9; i = i + 1)
        begin
            host_cpu_model_inst.access(1'b1, rows[i][24], rows[i][23:16],
                rows[i][15:0], q);
            if (rows[i][24])
                check("row read", rows[i][15:0], q);
        end
        host_cpu_model_inst.access(1'b0, 1'b0, 8'ha0, 16'h0000, q);
        host_cpu_model_inst.access(1'b1, 1'b1, 8'h20, 16'h0000, q);
        check("deselected wr", 16'h0020, q);
        hneed <= 1'b1;
        host_cpu_model_inst.grant(1'b0);
        repeat (6) @(posedge clk);
        check("hreq on", 16'h0001, {15'h0, hreq});
        check("hgnt on", 16'h0001, {15'h0, hgnt});
        check("preq off", 16'h0000, {15'h0, preq});
        hneed <= 1'b0;
        pneed <= 1'b1;
        repeat (6) @(posedge clk);
        check("hreq off", 16'h0000, {15'h0, hreq});
        check("preq on", 16'h0001, {15'h0, preq});
        check("pgnt split", 16'h0000, {15'h0, pgnt});
        host_cpu_model_inst.access(1'b1, 1'b0, 8'ha0, 16'h00a0, q);
        check("hreq shared", 16'h0001, {15'h0, hreq});
        check("preq shared", 16'h0000, {15'h0, preq});
        check("pgnt shared", 16'h0001, {15'h0, pgnt});
        // Acknowledge made active high: the low pin no longer grants
        host_cpu_model_inst.access(1'b1, 1'b0, 8'ha0, 16'h00e0, q);
        check("pgnt ack low", 16'h0000, {15'h0, pgnt});
        host_cpu_model_inst.grant(1'b1);
        repeat (6) @(posedge clk);
        check("pgnt ack high", 16'h0001, {15'h0, pgnt});
        // A second buffer word must not disturb the first
        baddr <= 6'h2a;
        host_cpu_model_inst.access(1'b1, 1'b0, 8'h40, 16'h1234, q);
        host_cpu_model_inst.access(1'b1, 1'b1, 8'h40, 16'h0000, q);
        check("buf word 2a", 16'h1234, q);
        baddr <= 6'h05;
        host_cpu_model_inst.access(1'b1, 1'b1, 8'h40, 16'h0000, q);
        check("buf word 05", 16'h5a3c, q);
        // Reset in mid-run: requests idle, then active low again
        rst_n <= 1'b0;
        hneed <= 1'b1;
        @(posedge clk);
        check("hreq mid rst", 16'h0001, {15'h0, hreq});
        check("preq mid rst", 16'h0001, {15'h0, preq});
        check("pgnt mid rst", 16'h0000, {15'h0, pgnt});
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("hreq low act", 16'h0000, {15'h0, hreq});
        check("preq low act", 16'h0000, {15'h0, preq});
        check("hgnt ack idle", 16'h0000, {15'h0, hgnt});
        host_cpu_model_inst.access(1'b1, 1'b1, 8'h20, 16'h0000, q);
        check("cfg after rst", 16'h0000, q);
        report_and_stop;
    end
endmodule // host_bus_dma_request_port_tb_top
